/* src/hbpm_top.sv */
// Purpose: half-bridge pwm mapping control of an eight bridge gate driver
// Assumes: all inputs synchronous to i_mclk; config written before i_cs_n rises
// Notes:   gate phase codes per bridge feed the analog drivers
//          mode, map, detect and adapt inputs may change while i_cs_n is low;
//          only the strobe edge commits them; guard and blank times act live
//
// Functional notes
// [R1] unmapped bridge: mode 01 low on, 10 high on
// [R2] low-side static sequence mirrors high-side sequence
// [R3] mode 00/11 discharges both gates, static current
// [R4] after guard time both gates go hold-off
// [R5] command applied within 3 us of edge
// [R6] three pwm channels, one input pin each
// [R7] disabled channel drives no bridge
// [R8] 3-bit select picks bridge 1 to 8
// [R9] mode 01 pwm low side, 10 high side
// [R10] mode 00 or 11 blocks pwm
// [R11] controller sets 00, maps, then sets mode
// [R12] mapped bridge with mode 00 stays off
// [R13] double mapping: error, bridge off, flag set
// [R14] active off turns free-wheeling on
// [R15] detection off: pwm mosfet is active
// [R16] detection on: classify at guard time end
// [R17] above upper threshold: low side active
// [R18] below lower threshold: high side active
// [R19] between thresholds: next-on mosfet active
// [R20] pwm follows mode code, not classification
// [R21] short on/off time: pwm mosfet active
// [R22] adapt 10/11: pre-charge and pre-discharge applied
// [R23] adapt 00: no pre-charge, no pre-discharge
// [R24] adapt 01: only pre-discharge at init current
// [R25] conflict flag sticky until cleared
// [R26] conflicts re-evaluated on every config change
module hbpm_top #(
	parameter int NB = 8,
	parameter int NC = 3,
	parameter int TW = 8
) (
	// clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst_n,
	// command strobe
	input  wire logic                  i_cs_n,
	// configuration
	input  wire logic [2*NB-1:0]       i_bridge_drive_cfg,
	input  wire logic [NC-1:0]         i_pwm_chan_en,
	input  wire logic [3*NC-1:0]       i_pwm_chan_bridge_sel,
	input  wire logic                  i_generator_detect_en,
	input  wire logic [1:0]            i_gate_delay_adapt_sel,
	input  wire logic [TW-1:0]         i_active_crossfeed_guard_time,
	input  wire logic [TW-1:0]         i_freewheel_crossfeed_guard_time,
	input  wire logic [TW-1:0]         i_blank_time,
	input  wire logic                  i_map_err_clr,
	// pwm pins and comparators
	input  wire logic [NC-1:0]         i_pwm,
	input  wire logic [NB-1:0]         i_switch_node_above_upper,
	input  wire logic [NB-1:0]         i_switch_node_below_lower,
	// gate drive
	output logic [3*NB-1:0]            o_hs_gate,
	output logic [3*NB-1:0]            o_ls_gate,
	output logic [NB-1:0]              o_hs_on,
	output logic [NB-1:0]              o_ls_on,
	output logic [NB-1:0]              o_lowside_active,
	output logic [NB-1:0]              o_precharge_en,
	output logic [NB-1:0]              o_predischarge_en,
	output logic [NB-1:0]              o_predischarge_init,
	// status
	output logic [NB-1:0]              o_bridge_out_map_err_status,
	output logic                       o_spi_err
);
	import hbpm_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one-hot bridge decode of a channel select
	function automatic logic [NB-1:0] sel_dec(input logic [2:0] sel);
		logic [NB-1:0] v;
		v = '0;
		v[sel] = 1'b1; // [R8]
		return v;
	endfunction

	// mode code decodes, shared by mapping and gate selection
	// both off codes park the bridge
	function automatic logic mode_is_off(input logic [1:0] m);
		return (m == HBPM_MODE_OFF) || (m == HBPM_MODE_OFF2);
	endfunction

	// pwm on the low-side gate
	function automatic logic mode_is_low(input logic [1:0] m);
		return m == HBPM_MODE_LOW;
	endfunction

	// pwm on the high-side gate
	function automatic logic mode_is_high(input logic [1:0] m);
		return m == HBPM_MODE_HIGH;
	endfunction

	// ----------------------------------------
	// applied configuration
	// ----------------------------------------
	// apply pulse and applied copies of the configuration
	logic            apply;
	logic [2*NB-1:0] mode_q;
	logic [NC-1:0]   en_q;
	logic [3*NC-1:0] sel_q;
	logic            gen_q;
	logic [1:0]      agc_q;

	// strobe edge to a one-cycle apply pulse
	hbpm_cmd_sync u_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_cs_n  (i_cs_n),
		.o_apply (apply)
	);

	// latch command on apply; the sequencers take the live mode, the rest reads these copies,
	// so a command acts on all bridges in the same cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			mode_q <= '0;
			en_q   <= '0;
			sel_q  <= '0;
			gen_q  <= 1'b0;
			agc_q  <= HBPM_AGC_NONE;
		end else if (apply) begin
			mode_q <= i_bridge_drive_cfg; // [R5]
			en_q   <= i_pwm_chan_en;
			sel_q  <= i_pwm_chan_bridge_sel;
			gen_q  <= i_generator_detect_en;
			agc_q  <= i_gate_delay_adapt_sel;
		end
	end

	// ----------------------------------------
	// mapping and conflicts
	// ----------------------------------------
	logic [NB-1:0] map_cnt_ge1;
	logic [NB-1:0] map_cnt_ge2;
	logic [NB-1:0] bridge_pwm;
	// combinational from applied config, so every change re-evaluates;
	// ge1 marks bridges with at least one enabled channel, ge2 those
	// picked by two or more, which is a mapping conflict
	always_comb begin
		logic [NB-1:0] hit;
		map_cnt_ge1 = '0;
		map_cnt_ge2 = '0;
		bridge_pwm  = '0;
		hit         = '0;
		for (int c = 0; c < NC; c++) begin
			if (en_q[c]) begin // [R7]
				hit = sel_dec(sel_q[3*c +: 3]);
				// a second hit on a bridge marks a conflict
				map_cnt_ge2 = map_cnt_ge2 | (map_cnt_ge1 & hit); // [R26]
				map_cnt_ge1 = map_cnt_ge1 | hit;
				if (i_pwm[c]) // [R6]
					bridge_pwm = bridge_pwm | hit;
			end
		end
	end

	// sticky conflict flags, set wins over clear: a conflict that is
	// still present when software clears comes straight back
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			o_bridge_out_map_err_status <= '0;
		else
			o_bridge_out_map_err_status <= map_cnt_ge2 | // [R13]
				(o_bridge_out_map_err_status & ~{NB{i_map_err_clr}}); // [R25]
	end

	// error level follows the live conflict, the flags keep the history
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			o_spi_err <= 1'b0;
		else
			o_spi_err <= |map_cnt_ge2; // [R13]
	end

	// ----------------------------------------
	// per bridge logic
	// ----------------------------------------
	// each bridge has its own static sequencer, pwm level timer,
	// role detector and registered gate outputs; they share only the
	// configuration inputs, the apply pulse and the mapping vectors above
	genvar b;
	generate
		for (b = 0; b < NB; b++) begin : g_br
			// mapping view of this bridge
			logic [1:0]   md;
			logic         pwm_on;
			logic         low_pwm;
			logic         high_pwm;
			logic         conflict;

			// role detection
			logic         low_act;
			logic         pwm_q;
			logic [TW-1:0] tcnt;
			logic          long_ok;

			// gate phases, static and selected
			hbpm_gate_t   st_hs;
			hbpm_gate_t   st_ls;
			hbpm_gate_t   hs_g;
			hbpm_gate_t   ls_g;

			assign md       = mode_q[2*b +: 2];
			assign conflict = map_cnt_ge2[b];
			// the pwm side comes from the mode code alone
			assign low_pwm  = map_cnt_ge1[b] && mode_is_low(md); // [R9]
			assign high_pwm = map_cnt_ge1[b] && mode_is_high(md); // [R9]
			assign pwm_on   = bridge_pwm[b];

			// the sequencer takes the live mode at the apply edge,
			// the same edge at which the copies above are taken
			hbpm_static_seq #(.TW(TW)) u_seq (
				.i_mclk      (i_mclk),
				.i_rst_n     (i_rst_n),
				.i_apply     (apply),
				.i_mode      (i_bridge_drive_cfg[2*b +: 2]),
				.i_ccp_cyc   (i_active_crossfeed_guard_time),
				.i_blank_cyc (i_blank_time),
				.o_hs        (st_hs),
				.o_ls        (st_ls)
			);

			// length of the current pwm level, for the detection window;
			// saturates, so very long levels still count as long enough
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					pwm_q <= 1'b0;
					tcnt  <= '0;
				end else begin
					pwm_q <= pwm_on;
					if (pwm_q != pwm_on)
						tcnt <= '0;
					else if (tcnt != {TW{1'b1}})
						tcnt <= tcnt + 1'b1;
				end
			end
			// on-time vs fw guard, off-time vs active guard
			assign long_ok = pwm_q ? (tcnt >= i_freewheel_crossfeed_guard_time)
				: (tcnt >= i_active_crossfeed_guard_time);

			// active/free-wheeling classification, judged at each pwm edge
			// if the level before the edge lasted its guard time; a level
			// too short for that leaves the pwm mosfet as the active one
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n)
					low_act <= 1'b0;
				else if (!gen_q || !(low_pwm || high_pwm))
					low_act <= low_pwm; // [R15]
				else if (pwm_q != pwm_on) begin
					if (!long_ok)
						low_act <= low_pwm; // [R21]
					else if (i_switch_node_above_upper[b])
						low_act <= 1'b1; // [R16] [R17]
					else if (i_switch_node_below_lower[b])
						low_act <= 1'b0; // [R18]
					else
						low_act <= (pwm_on == low_pwm); // [R19]
				end
			end

			// gate selection: pwm waveform on the mode's mosfet; a conflict
			// overrides everything, so a double mapping can never drive
			always_comb begin
				hs_g = st_hs;
				ls_g = st_ls;
				if (conflict) begin
					hs_g = HBPM_G_HOLD_OFF; // [R13]
					ls_g = HBPM_G_HOLD_OFF;
				end else if (map_cnt_ge1[b] && mode_is_off(md)) begin
					// mapped but parked: high impedance, pin ignored
					hs_g = HBPM_G_HOLD_OFF; // [R10] [R12]
					ls_g = HBPM_G_HOLD_OFF;
				end else if (low_pwm || high_pwm) begin
					hs_g = HBPM_G_PWM; // [R20]
					ls_g = HBPM_G_PWM;
				end
				// unmapped bridges keep the static sequencer output [R1]
			end

			// gate on levels, registered; exactly one gate on in pwm mode
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					o_hs_on[b] <= 1'b0;
					o_ls_on[b] <= 1'b0;
				end else if (hs_g == HBPM_G_PWM) begin
					// pwm mosfet follows pin, opposite free-wheels [R14]
					o_hs_on[b] <= high_pwm ? pwm_on : !pwm_on; // [R20]
					o_ls_on[b] <= low_pwm ? pwm_on : !pwm_on;
				end else begin
					o_hs_on[b] <= hs_g == HBPM_G_STAT_ON || hs_g == HBPM_G_HOLD_ON; // [R1]
					o_ls_on[b] <= ls_g == HBPM_G_STAT_ON || ls_g == HBPM_G_HOLD_ON;
				end
			end

			// phase codes towards the analog gate drivers
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					o_hs_gate[3*b +: 3] <= HBPM_G_HOLD_OFF;
					o_ls_gate[3*b +: 3] <= HBPM_G_HOLD_OFF;
				end else begin
					o_hs_gate[3*b +: 3] <= hs_g;
					o_ls_gate[3*b +: 3] <= ls_g;
				end
			end

			// role of the low side, one cycle after the detector
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n)
					o_lowside_active[b] <= 1'b0;
				else
					o_lowside_active[b] <= low_act;
			end

			// adaptive scheme, only while the bridge follows its pin
			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					o_precharge_en[b]      <= 1'b0;
					o_predischarge_en[b]   <= 1'b0;
					o_predischarge_init[b] <= 1'b0;
				end else begin
					if (hs_g == HBPM_G_PWM) begin
						o_precharge_en[b]      <= agc_q[1]; // [R22] [R23] [R24]
						o_predischarge_en[b]   <= agc_q != HBPM_AGC_NONE; // [R23]
						o_predischarge_init[b] <= agc_q == HBPM_AGC_INIT; // [R24]
					end else begin
						o_precharge_en[b]      <= 1'b0;
						o_predischarge_en[b]   <= 1'b0;
						o_predischarge_init[b] <= 1'b0;
					end
				end
			end
		end
	endgenerate
	// the start order of [R11] is the controller's duty; conflicts and
	// mode 00 blocking above keep the bridge safe if it is broken.
	// active guard and blank counts are read live by the sequencers, both guard counts by the detectors, so they
	// should only be changed while the affected bridges are idle
endmodule

/* src/hbpm_pkg.sv */
// Purpose: shared constants and types for the half-bridge pwm mapping control
// Assumes: 10 MHz system clock
// Notes:   mode codes, gate current phases and timing counts
package hbpm_pkg;
	localparam int          HBPM_NUM_BRIDGE = 8;
	localparam int          HBPM_NUM_CHAN   = 3;
	localparam logic [1:0]  HBPM_MODE_OFF   = 2'h0;
	localparam logic [1:0]  HBPM_MODE_LOW   = 2'h1;
	localparam logic [1:0]  HBPM_MODE_HIGH  = 2'h2;
	localparam logic [1:0]  HBPM_MODE_OFF2  = 2'h3;
	localparam logic [1:0]  HBPM_AGC_NONE   = 2'h0;
	localparam logic [1:0]  HBPM_AGC_INIT   = 2'h1;
	// command apply latest time and clock rate
	localparam int          HBPM_CLK_HZ        = 10_000_000;
	localparam int          HBPM_APPLY_MAX_NS  = 3000;
	localparam int          HBPM_APPLY_CYC     = HBPM_APPLY_MAX_NS / (1_000_000_000 / HBPM_CLK_HZ);
	localparam int          HBPM_TIMER_W       = 8;
	// gate drive phase per gate
	typedef enum logic [2:0] {
		HBPM_G_HOLD_OFF = 3'h0, // -hold current
		HBPM_G_STAT_OFF = 3'h1, // -static current
		HBPM_G_HARD_OFF = 3'h3, // -hard off current
		HBPM_G_STAT_ON  = 3'h2, // +static current
		HBPM_G_HOLD_ON  = 3'h6, // +hold current
		HBPM_G_PWM      = 3'h7  // gate follows pwm scheme
	} hbpm_gate_t;
	// static sequencer states, gray along usual path
	typedef enum logic [1:0] {
		HBPM_S_IDLE  = 2'h0,
		HBPM_S_CCP   = 2'h1,
		HBPM_S_BLANK = 2'h3,
		HBPM_S_HOLD  = 2'h2
	} hbpm_state_t;
endpackage

/* src/hbpm_cmd_sync.sv */
// Purpose: synchronise command strobe edge and release the command in time
// Assumes: i_cs_n sampled synchronously to i_mclk
// Notes:   apply pulse comes a fixed number of cycles after the rising edge
module hbpm_cmd_sync (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// chip select level
	input  wire logic i_cs_n,
	// apply strobe
	output logic      o_apply
);
	import hbpm_pkg::*;
	logic                    cs_q1;
	logic                    cs_q2;
	logic                    cs_q3;
	logic [HBPM_TIMER_W-1:0] cnt;
	logic                    busy;
	// two-stage sync then edge stage
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cs_q1 <= 1'b1;
			cs_q2 <= 1'b1;
			cs_q3 <= 1'b1;
		end else begin
			cs_q1 <= i_cs_n;
			cs_q2 <= cs_q1;
			cs_q3 <= cs_q2;
		end
	end
	// short delay after edge, well within the latest apply time
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			busy <= 1'b0;
			cnt  <= '0;
		end else if (cs_q2 && !cs_q3) begin
			busy <= 1'b1; // [R5]
			cnt  <= '0;
		end else if (busy) begin
			cnt  <= cnt + 1'b1;
			busy <= (cnt != HBPM_TIMER_W'(1)); // pulse stands in the second busy cycle
		end
	end
	assign o_apply = busy && (cnt == HBPM_TIMER_W'(1));
endmodule

/* src/hbpm_static_seq.sv */
// Purpose: static sequence of one half-bridge gate pair
// Assumes: mode and guard times are stable between apply pulses
// Notes:   high-side sequence, low side handled by swapping roles
module hbpm_static_seq #(
	parameter int TW = 8
) (
	// clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst_n,
	// command
	input  wire logic                  i_apply,
	input  wire logic [1:0]            i_mode,
	input  wire logic [TW-1:0]         i_ccp_cyc,
	input  wire logic [TW-1:0]         i_blank_cyc,
	// gate phases
	output hbpm_pkg::hbpm_gate_t       o_hs,
	output hbpm_pkg::hbpm_gate_t       o_ls
);
	import hbpm_pkg::*;
	hbpm_state_t state;
	logic [TW-1:0] cnt;
	logic [1:0]    mode;
	logic          new_on;
	hbpm_gate_t    on_g;
	hbpm_gate_t    off_g;
	logic          on_mode;
	// on_mode follows the applied mode only, so inputs written ahead
	// of the strobe cannot disturb a running phase
	assign on_mode = (mode == HBPM_MODE_LOW) || (mode == HBPM_MODE_HIGH);
	assign new_on  = (i_mode == HBPM_MODE_LOW) || (i_mode == HBPM_MODE_HIGH);
	// phase sequencer
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state   <= HBPM_S_HOLD;
			cnt     <= '0;
			mode    <= HBPM_MODE_OFF;
		end else if (i_apply && i_mode != mode) begin
			mode    <= i_mode;
			cnt     <= '0;
			// off, or turn-on from an on state, starts with ccp [R3]
			if (!new_on || on_mode)
				state <= HBPM_S_CCP;
			else
				state <= HBPM_S_BLANK;
		end else begin
			case (state)
				HBPM_S_CCP: begin
					cnt <= cnt + 1'b1;
					if (cnt + 1'b1 >= i_ccp_cyc) begin
						cnt   <= '0;
						state <= on_mode ? HBPM_S_BLANK : HBPM_S_HOLD; // [R4]
					end
				end
				HBPM_S_BLANK: begin
					cnt <= cnt + 1'b1;
					if (cnt + 1'b1 >= i_blank_cyc)
						state <= HBPM_S_HOLD;
				end
				HBPM_S_HOLD: state <= HBPM_S_HOLD;
				default: state <= HBPM_S_HOLD;
			endcase
		end
	end
	// phase to gate currents for the turned-on and opposite gate
	always_comb begin
		on_g  = HBPM_G_HOLD_OFF;
		off_g = HBPM_G_HOLD_OFF;
		case (state)
			HBPM_S_CCP: begin
				on_g  = HBPM_G_STAT_OFF;
				off_g = HBPM_G_STAT_OFF;
			end
			HBPM_S_BLANK: begin
				on_g  = HBPM_G_STAT_ON;
				off_g = HBPM_G_HARD_OFF;
			end
			HBPM_S_HOLD: begin
				on_g  = on_mode ? HBPM_G_HOLD_ON : HBPM_G_HOLD_OFF;
				off_g = HBPM_G_HOLD_OFF;
			end
			default: begin
				on_g  = HBPM_G_HOLD_OFF;
				off_g = HBPM_G_HOLD_OFF;
			end
		endcase
	end
	// low-side mode swaps the roles [R2]
	assign o_hs = (mode == HBPM_MODE_LOW) ? off_g : on_g;
	assign o_ls = (mode == HBPM_MODE_LOW) ? on_g : off_g;
endmodule

/* test/hbpm_top_chk.sv */
// Purpose: port assertions of the half-bridge pwm mapping control
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the top module at the foot of this file
module hbpm_top_chk
	import hbpm_pkg::*;
#(
	parameter int NB = 8
) (
	// clock and reset
	input wire logic            i_mclk,
	input wire logic            i_rst_n,
	// watched ports
	input wire logic            i_map_err_clr,
	input wire logic            o_spi_err,
	input wire logic [3*NB-1:0] o_hs_gate,
	input wire logic [3*NB-1:0] o_ls_gate,
	input wire logic [NB-1:0]   o_hs_on,
	input wire logic [NB-1:0]   o_ls_on,
	input wire logic [NB-1:0]   o_precharge_en,
	input wire logic [NB-1:0]   o_predischarge_en,
	input wire logic [NB-1:0]   o_bridge_out_map_err_status
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	// gates still clear on the first edge after reset
	property p_rst_clear;
		$rose(i_rst_n) |-> o_hs_gate == '0 && o_ls_gate == '0 && !o_spi_err;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("gates set after reset");
	// an error level always has a flag behind it
	property p_err_any;
		o_spi_err |-> o_bridge_out_map_err_status != '0;
	endproperty
	a_err_any: assert property (p_err_any) else $error("error without flag");
	// per-bridge relations
	for (genvar b = 0; b < NB; b++) begin : g_br
		property p_no_cross;
			!(o_hs_on[b] && o_ls_on[b]);
		endproperty
		a_no_cross: assert property (p_no_cross) else $error("both gates on");
		property p_hs_on_code;
			o_hs_on[b] |-> o_hs_gate[3*b+:3] inside {HBPM_G_STAT_ON, HBPM_G_HOLD_ON, HBPM_G_PWM};
		endproperty
		a_hs_on_code: assert property (p_hs_on_code) else $error("hs on, off code");
		property p_ls_on_code;
			o_ls_on[b] |-> o_ls_gate[3*b+:3] inside {HBPM_G_STAT_ON, HBPM_G_HOLD_ON, HBPM_G_PWM};
		endproperty
		a_ls_on_code: assert property (p_ls_on_code) else $error("ls on, off code");
		property p_err_off;
			$rose(o_bridge_out_map_err_status[b]) |-> ##[0:3] !o_hs_on[b] && !o_ls_on[b];
		endproperty
		a_err_off: assert property (p_err_off) else $error("conflict bridge on");
		property p_flag_hold;
			$fell(o_bridge_out_map_err_status[b]) |-> $past(i_map_err_clr);
		endproperty
		a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
		property p_pre_pwm;
			o_precharge_en[b] || o_predischarge_en[b]
				|-> o_hs_gate[3*b+:3] == HBPM_G_PWM || o_ls_gate[3*b+:3] == HBPM_G_PWM;
		endproperty
		a_pre_pwm: assert property (p_pre_pwm) else $error("pre phase off pwm");
	end
endmodule

bind hbpm_top hbpm_top_chk #(.NB(NB)) chk_u (
	.i_mclk, .i_rst_n, .i_map_err_clr, .o_spi_err, .o_hs_gate, .o_ls_gate,
	.o_hs_on, .o_ls_on, .o_precharge_en, .o_predischarge_en, .o_bridge_out_map_err_status
);

/* test/hbpm_mcu.sv */
// Purpose: controller model driving command strobe and three pwm pins
// Assumes: pins change on the falling clock edge
// Notes:   channels share period and high time, phases staggered
module hbpm_mcu (
	// clock
	input  wire logic       i_mclk,
	// pwm period and high time in cycles
	input  wire logic [7:0] i_per,
	input  wire logic [7:0] i_high,
	// pins towards the driver
	output logic [2:0]      o_pwm,
	output logic            o_cs_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt;
	// idle pins at time zero
	initial begin
		cnt = 8'h00;
		o_pwm = 3'h0;
		o_cs_n = 1'b1;
	end
	// one free-running counter, one pin per channel
	always @(negedge i_mclk) begin
		cnt <= (cnt + 8'h01 >= i_per) ? 8'h00 : cnt + 8'h01;
		for (int c = 0; c < 3; c++) begin
			o_pwm[c] <= ((cnt + 8'(7 * c)) % i_per) < i_high;
		end
	end
	// strobe low then high, return once outputs carry the command
	task automatic command();
		@(negedge i_mclk);
		o_cs_n <= 1'b0;
		@(negedge i_mclk);
		o_cs_n <= 1'b1;
		repeat (6) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask
endmodule

/* test/test_half_bridge_pwm_mapping_ctrl.sv */
// Purpose: self-checking bench of the half-bridge pwm mapping control
// Assumes: guard 6, freewheel guard 4, blank 8 cycles
// Notes:   pwm timing and channel picks drawn from a fixed seed
module test_half_bridge_pwm_mapping_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import hbpm_pkg::*;
	logic        i_mclk, i_rst_n, i_cs_n, i_generator_detect_en, i_map_err_clr, o_spi_err;
	logic [1:0]  i_gate_delay_adapt_sel;
	logic [2:0]  i_pwm_chan_en, i_pwm;
	logic [8:0]  i_pwm_chan_bridge_sel;
	logic [15:0] i_bridge_drive_cfg;
	logic [23:0] o_hs_gate, o_ls_gate;
	logic [7:0]  i_switch_node_above_upper, i_switch_node_below_lower, o_hs_on, o_ls_on;
	logic [7:0]  o_lowside_active, o_precharge_en, o_predischarge_en, o_predischarge_init;
	logic [7:0]  o_bridge_out_map_err_status, pwm_per, pwm_high, seen;
	logic [7:0]  guard_act, guard_fw, blank_cyc;
	logic [31:0] seed;
	int          fail_count, total_checks;
	hbpm_top #(.NB(8), .NC(3), .TW(8)) dut_u (
		.i_mclk, .i_rst_n, .i_cs_n, .i_bridge_drive_cfg, .i_pwm_chan_en,
		.i_pwm_chan_bridge_sel, .i_generator_detect_en, .i_gate_delay_adapt_sel,
		.i_active_crossfeed_guard_time(guard_act), .i_freewheel_crossfeed_guard_time(guard_fw),
		.i_blank_time(blank_cyc), .i_map_err_clr, .i_pwm, .i_switch_node_above_upper,
		.i_switch_node_below_lower, .o_hs_gate, .o_ls_gate, .o_hs_on, .o_ls_on,
		.o_lowside_active, .o_precharge_en, .o_predischarge_en, .o_predischarge_init,
		.o_bridge_out_map_err_status, .o_spi_err
	);
	hbpm_mcu mcu_u (.i_mclk, .i_per(pwm_per), .i_high(pwm_high), .o_pwm(i_pwm), .o_cs_n(i_cs_n));
	// 10 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// settled static code of one gate for a mode
	function automatic logic [7:0] settled(logic [1:0] m, logic hs);
		return ((hs ? HBPM_MODE_HIGH : HBPM_MODE_LOW) == m) ? 8'(HBPM_G_HOLD_ON) : 8'h00;
	endfunction
	// expected {precharge, predischarge, init current} seen per scheme
	function automatic logic [7:0] adapt_exp(logic [1:0] a);
		return {5'h00, a[1], a != 2'h0, a == 2'h1};
	endfunction
	function automatic logic [7:0] hsg(int b);
		return 8'(o_hs_gate[3*b+:3]);
	endfunction
	function automatic logic [7:0] lsg(int b);
		return 8'(o_ls_gate[3*b+:3]);
	endfunction
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_n(int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task automatic results();
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (30000) @(posedge i_mclk);
		fail_count++;
		results();
	end
	// main sequence
	initial begin
		{i_rst_n, i_generator_detect_en, i_map_err_clr, i_gate_delay_adapt_sel} = '0;
		{i_pwm_chan_en, i_pwm_chan_bridge_sel, i_bridge_drive_cfg} = '0;
		{i_switch_node_above_upper, i_switch_node_below_lower} = '0;
		{fail_count, total_checks} = '0;
		{guard_act, guard_fw, blank_cyc} = {8'h06, 8'h04, 8'h08};
		seed = 32'h09655D65;
		pwm_per = 8'h1E;
		pwm_high = 8'h0C;
		repeat (10) @(posedge i_mclk);
		@(negedge i_mclk);
		i_rst_n = 1'b1;
		chk("reset code", 8'h00, hsg(0));
		// static on, swap sides through the guard, then off
		for (int b = 0; b < 8; b++) begin
			i_bridge_drive_cfg[2*b+:2] = HBPM_MODE_HIGH;
			mcu_u.command();
			wait_n(24);
			chk("hs static on", settled(HBPM_MODE_HIGH, 1'b1), hsg(b));
			i_bridge_drive_cfg[2*b+:2] = HBPM_MODE_LOW;
			mcu_u.command();
			chk("guard hs", 8'h01, hsg(b));
			chk("guard ls", 8'h01, lsg(b));
			wait_n(8);
			chk("ls charging", 8'h02, lsg(b));
			chk("hs hard off", 8'h03, hsg(b));
			wait_n(20);
			chk("ls static on", settled(HBPM_MODE_LOW, 1'b0), lsg(b));
			chk("hs held off", settled(HBPM_MODE_LOW, 1'b1), hsg(b));
			i_bridge_drive_cfg[2*b+:2] = rnd() % 2 ? HBPM_MODE_OFF2 : HBPM_MODE_OFF;
			mcu_u.command();
			chk("off hs", 8'h01, hsg(b));
			chk("off ls", 8'h01, lsg(b));
			wait_n(10);
			chk("hold hs", 8'h00, hsg(b));
			chk("hold ls", 8'h00, lsg(b));
		end
		// pwm mapping on every bridge, channel from the bridge number, side from the seed
		for (int b = 0; b < 8; b++) begin
			int         c;
			int         c2;
			logic [1:0] m;
			c = b % 3;
			c2 = (c + 1 + rnd() % 2) % 3;
			m = rnd() % 2 ? HBPM_MODE_HIGH : HBPM_MODE_LOW;
			pwm_per = 8'(30 + rnd() % 32);
			pwm_high = 8'(10 + rnd() % (pwm_per - 20));
			i_pwm_chan_bridge_sel[3*c+:3] = 3'(b);
			i_pwm_chan_en[c] = 1'b1;
			mcu_u.command();
			wait_n(40);
			chk("mapped idle", 8'h00, {6'h00, o_hs_on[b], o_ls_on[b]});
			i_bridge_drive_cfg[2*b+:2] = m;
			mcu_u.command();
			seen = '0;
			repeat (60) begin
				@(negedge i_mclk);
				seen = seen | {6'h00, o_hs_on[b], o_ls_on[b]};
			end
			chk("both sides used", 8'h03, seen);
			chk("pwm gate", 8'(HBPM_G_PWM), m == HBPM_MODE_HIGH ? hsg(b) : lsg(b));
			chk("low active", {7'h00, m == HBPM_MODE_LOW}, {7'h00, o_lowside_active[b]});
			i_generator_detect_en = 1'b1;
			i_switch_node_above_upper[b] = 1'b1;
			mcu_u.command();
			wait_n(60);
			chk("upper", 8'h01, {7'h00, o_lowside_active[b]});
			i_switch_node_above_upper[b] = 1'b0;
			i_switch_node_below_lower[b] = 1'b1;
			wait_n(60);
			chk("lower", 8'h00, {7'h00, o_lowside_active[b]});
			i_switch_node_below_lower[b] = 1'b0;
			seen = '0;
			repeat (60) begin
				@(negedge i_mclk);
				seen = seen | (8'h01 << o_lowside_active[b]);
			end
			chk("between", 8'h03, seen);
			pwm_per = 8'h06;
			pwm_high = 8'h03;
			i_switch_node_above_upper[b] = 1'b1;
			wait_n(20);
			chk("short pwm", {7'h00, m == HBPM_MODE_LOW}, {7'h00, o_lowside_active[b]});
			i_switch_node_above_upper[b] = 1'b0;
			i_generator_detect_en = 1'b0;
			for (int a = 0; a < 4; a++) begin
				i_gate_delay_adapt_sel = 2'(a);
				mcu_u.command();
				seen = '0;
				repeat (130) begin
					@(negedge i_mclk);
					seen = seen | {5'h00, o_precharge_en[b], o_predischarge_en[b],
						o_predischarge_init[b]};
				end
				chk("adapt phases", adapt_exp(2'(a)), seen);
			end
			i_gate_delay_adapt_sel = 2'h0;
			i_pwm_chan_bridge_sel[3*c2+:3] = 3'(b);
			i_pwm_chan_en[c2] = 1'b1;
			mcu_u.command();
			wait_n(4);
			chk("conflict err", 8'h01, {7'h00, o_spi_err});
			chk("conflict flag", 8'h01, {7'h00, o_bridge_out_map_err_status[b]});
			chk("conflict off", 8'h00, {6'h00, o_hs_on[b], o_ls_on[b]});
			i_pwm_chan_en[c2] = 1'b0;
			mcu_u.command();
			chk("conflict gone", 8'h00, {7'h00, o_spi_err});
			chk("flag kept", 8'h01, {7'h00, o_bridge_out_map_err_status[b]});
			i_map_err_clr = 1'b1;
			wait_n(1);
			i_map_err_clr = 1'b0;
			wait_n(1);
			chk("flag cleared", 8'h00, {7'h00, o_bridge_out_map_err_status[b]});
			i_pwm_chan_en[c] = 1'b0;
			mcu_u.command();
			wait_n(30);
			chk("unmapped static", settled(m, 1'b1), hsg(b));
			i_pwm_chan_en[c] = 1'b1;
			i_bridge_drive_cfg[2*b+:2] = HBPM_MODE_OFF2;
			mcu_u.command();
			wait_n(20);
			chk("blocked hs", 8'h00, hsg(b));
			chk("blocked ls", 8'h00, lsg(b));
			i_pwm_chan_en[c] = 1'b0;
			i_bridge_drive_cfg[2*b+:2] = HBPM_MODE_OFF;
			mcu_u.command();
		end
		results();
	end
endmodule
